/* File: verilog/ptb_regs.svh */
// Register offsets, field positions, reset values, write mask and event numbers of the PWM time base block
`ifndef PTB_REGS_SVH
`define PTB_REGS_SVH
`define PTB_OFF_PERIOD 12'h000
`define PTB_OFF_SEVT 12'h004
`define PTB_OFF_GCTL 12'h008
`define PTB_OFF_TIMER 12'h00c
`define PTB_OFF_IRQ_STATUS 12'h010
`define PTB_OFF_IRQ_CLEAR 12'h014
`define PTB_OFF_IRQ_ENABLE 12'h018
`define PTB_RST_PERIOD 16'hfff8
`define PTB_RST_SEVT 16'h0000
`define PTB_RST_GCTL 16'h0000
`define PTB_BIT_FLT_STAT 15
`define PTB_BIT_CL_STAT 14
`define PTB_BIT_TRG_STAT 13
`define PTB_BIT_FLT_IEN 12
`define PTB_BIT_CL_IEN 11
`define PTB_BIT_TRG_IEN 10
`define PTB_GCTL_WMASK 16'h1fef
`define PTB_EVT_FAULT 0
`define PTB_EVT_CLIMIT 1
`define PTB_EVT_TRIGGER 2
`define PTB_EVT_SPECIAL 3
`define PTB_EVT_PERIOD 4
`endif

/* File: verilog/ptb_pkg.sv */
// Types shared by the PWM time base block
package ptb_pkg;
   typedef enum logic [1:0] {ptb_idle, ptb_access} ptb_apb_state_t;
   typedef logic [4:0] ptb_evt_t;
endpackage

/* File: verilog/ptb_timer_if.sv */
// Signals between the register file and the master time base
`timescale 1ns/1ps
interface ptb_timer_if;
   logic [15:0] period;
   logic [15:0] compare;
   logic [15:0] count;
   logic period_hit;
   logic special_hit;
   modport timer (input period, input compare, output count, output period_hit, output special_hit);
   modport ctrl (output period, output compare, input count, input period_hit, input special_hit);
endinterface

/* File: verilog/ptb_timer.sv */
// Primary master time base counter with period and special event compare
`timescale 1ns/1ps
`include "ptb_regs.svh"
module ptb_timer
   import ptb_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   ptb_timer_if.timer tif
);
   logic [15:0] count;
   logic [15:0] next_count;
   logic period_hit;
   logic next_period_hit;
   logic special_hit;
   logic next_special_hit;

   always_comb
   begin
      next_period_hit = (count >= tif.period);
      next_count = next_period_hit ? 16'h0000 : count + 16'h0001;
      next_special_hit = (count == tif.compare);
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         count <= 16'h0000;
         period_hit <= 1'b0;
         special_hit <= 1'b0;
      end
      else
      begin
         count <= next_count;
         period_hit <= next_period_hit;
         special_hit <= next_special_hit;
      end
   end

   assign tif.count = count;
   assign tif.period_hit = period_hit;
   assign tif.special_hit = special_hit;
endmodule // ptb_timer

/* File: verilog/ptb_top.sv */
// APB register file, generator status flags and interrupt logic of the PWM time base block
`timescale 1ns/1ps
`include "ptb_regs.svh"
module ptb_top
   import ptb_pkg::*;
#(
   parameter int REG_WIDTH = 16,
   parameter int EVT_COUNT = 5
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fault_event,
   input wire logic current_limit_event,
   input wire logic trigger_event,
   output logic special_event,
   output logic irq
);
   ptb_timer_if tif();

   // The register file and the timer serve 16-bit registers and five interrupt events only
   if (REG_WIDTH != 16 || EVT_COUNT != $bits(ptb_evt_t))
   begin : g_param_check
      $error("ptb_top: unsupported register width or event count");
   end

   ptb_timer ptb_timer_i
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .tif(tif)
   );

   ptb_apb_state_t state;
   ptb_apb_state_t next_state;
   logic [15:0] primary_period_value;
   logic [15:0] next_primary_period_value;
   logic [15:0] special_event_compare_value;
   logic [15:0] next_special_event_compare_value;
   logic [15:0] generator_control_reg;
   logic [15:0] next_generator_control_reg;
   ptb_evt_t irq_status;
   ptb_evt_t next_irq_status;
   ptb_evt_t irq_enable;
   ptb_evt_t next_irq_enable;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_special_event;
   logic next_irq;
   logic wr;
   logic [15:0] wval;
   logic [15:0] gctl_new;
   logic fault_irq_enable;
   logic current_limit_irq_enable;
   logic trigger_irq_enable;

   // Merge a write into a 16-bit register honouring byte strobes
   function automatic logic [15:0] ptb_merge(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      ptb_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   function automatic logic ptb_mapped(input logic [11:0] a);
      ptb_mapped = (a == `PTB_OFF_PERIOD) || (a == `PTB_OFF_SEVT) || (a == `PTB_OFF_GCTL) ||
                   (a == `PTB_OFF_TIMER) || (a == `PTB_OFF_IRQ_STATUS) || (a == `PTB_OFF_IRQ_CLEAR) ||
                   (a == `PTB_OFF_IRQ_ENABLE);
   endfunction

   assign tif.period = primary_period_value;
   assign tif.compare = special_event_compare_value;
   assign fault_irq_enable = generator_control_reg[`PTB_BIT_FLT_IEN];
   assign current_limit_irq_enable = generator_control_reg[`PTB_BIT_CL_IEN];
   assign trigger_irq_enable = generator_control_reg[`PTB_BIT_TRG_IEN];

   // One wait state: the answer is registered at the access edge
   always_comb
   begin
      next_state = state;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      wr = 1'b0;
      case (state)
         ptb_idle:
         begin
            if (psel && !penable)
               next_state = ptb_access;
         end
         ptb_access:
         begin
            if (psel && penable)
            begin
               next_pready = 1'b1;
               next_pslverr = !ptb_mapped(paddr);
               wr = pwrite && ptb_mapped(paddr);
               next_state = ptb_idle;
               next_prdata = 32'h0000_0000;
               if (!pwrite)
               begin
                  case (paddr)
                     `PTB_OFF_PERIOD: next_prdata = {16'h0000, primary_period_value};
                     `PTB_OFF_SEVT: next_prdata = {16'h0000, special_event_compare_value};
                     `PTB_OFF_GCTL: next_prdata = {16'h0000, generator_control_reg};
                     `PTB_OFF_TIMER: next_prdata = {16'h0000, tif.count};
                     `PTB_OFF_IRQ_STATUS: next_prdata = {27'h0000000, irq_status};
                     `PTB_OFF_IRQ_ENABLE: next_prdata = {27'h0000000, irq_enable};
                     default: next_prdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         default: next_state = ptb_idle;
      endcase
   end

   // Register writes and hardware status flags
   always_comb
   begin
      wval = 16'h0000;
      next_primary_period_value = primary_period_value;
      next_special_event_compare_value = special_event_compare_value;
      next_irq_enable = irq_enable;
      next_irq_status = irq_status;
      gctl_new = generator_control_reg;
      if (wr && paddr == `PTB_OFF_PERIOD)
         next_primary_period_value = ptb_merge(primary_period_value, pwdata, pstrb);
      if (wr && paddr == `PTB_OFF_SEVT)
         next_special_event_compare_value = ptb_merge(special_event_compare_value, pwdata, pstrb);
      if (wr && paddr == `PTB_OFF_GCTL)
      begin
         wval = ptb_merge(generator_control_reg, pwdata, pstrb);
         gctl_new = (generator_control_reg & ~`PTB_GCTL_WMASK) | (wval & `PTB_GCTL_WMASK);
      end
      // Clearing an enable clears its flag; an event in that same cycle still sets it, later events do not
      if (!gctl_new[`PTB_BIT_CL_IEN])
         gctl_new[`PTB_BIT_CL_STAT] = 1'b0;
      if (!gctl_new[`PTB_BIT_FLT_IEN])
         gctl_new[`PTB_BIT_FLT_STAT] = 1'b0;
      if (!gctl_new[`PTB_BIT_TRG_IEN])
         gctl_new[`PTB_BIT_TRG_STAT] = 1'b0;
      if (current_limit_event && current_limit_irq_enable)
         gctl_new[`PTB_BIT_CL_STAT] = 1'b1;
      if (fault_event && fault_irq_enable)
         gctl_new[`PTB_BIT_FLT_STAT] = 1'b1;
      if (trigger_event && trigger_irq_enable)
         gctl_new[`PTB_BIT_TRG_STAT] = 1'b1;
      next_generator_control_reg = gctl_new;
      if (wr && paddr == `PTB_OFF_IRQ_ENABLE)
         next_irq_enable = pwdata[4:0];
      if (wr && paddr == `PTB_OFF_IRQ_CLEAR)
         next_irq_status = irq_status & ~pwdata[4:0];
      next_irq_status[`PTB_EVT_FAULT] = next_irq_status[`PTB_EVT_FAULT] | fault_event;
      next_irq_status[`PTB_EVT_CLIMIT] = next_irq_status[`PTB_EVT_CLIMIT] | current_limit_event;
      next_irq_status[`PTB_EVT_TRIGGER] = next_irq_status[`PTB_EVT_TRIGGER] | trigger_event;
      next_irq_status[`PTB_EVT_SPECIAL] = next_irq_status[`PTB_EVT_SPECIAL] | tif.special_hit;
      next_irq_status[`PTB_EVT_PERIOD] = next_irq_status[`PTB_EVT_PERIOD] | tif.period_hit;
      // A compare hit leaves as a one-cycle pulse
      next_special_event = tif.special_hit;
      next_irq = |(next_irq_status & next_irq_enable);
   end

   // Bus answer registers
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ptb_idle;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         state <= next_state;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Registers, status flags and interrupt outputs
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         primary_period_value <= `PTB_RST_PERIOD;
         special_event_compare_value <= `PTB_RST_SEVT;
         generator_control_reg <= `PTB_RST_GCTL;
         irq_status <= 5'h00;
         irq_enable <= 5'h00;
         special_event <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         primary_period_value <= next_primary_period_value;
         special_event_compare_value <= next_special_event_compare_value;
         generator_control_reg <= next_generator_control_reg;
         irq_status <= next_irq_status;
         irq_enable <= next_irq_enable;
         special_event <= next_special_event;
         irq <= next_irq;
      end
   end
endmodule // ptb_top

/* File: test/ptb_properties.sv */
// Concurrent checks on the APB port and status bits of the PWM time base block
`timescale 1ns/1ps
module ptb_checker
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire gc = pready && !pwrite && paddr == 12'h008;
   property p_ready_lat; psel && penable && !pready |=> pready; endproperty
   a_ready_lat: assert property (p_ready_lat) else $error("pready late");
   property p_ready_pulse; pready |=> !pready [*2]; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   property p_err_map; pready |-> pslverr == (paddr > 12'h018 || paddr[1:0] != 2'h0); endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr wrong");
   property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   property p_gctl_layout; gc |-> prdata[31:16] == 16'h0 && !prdata[4]; endproperty
   a_gctl_layout: assert property (p_gctl_layout) else $error("control layout");
   property p_cl; gc |-> !prdata[14] || prdata[11]; endproperty
   a_cl: assert property (p_cl) else $error("limit flag without enable");
   property p_trg; gc |-> !prdata[13] || prdata[10]; endproperty
   a_trg: assert property (p_trg) else $error("trigger flag without enable");
   property p_flt; gc |-> !prdata[15] || prdata[12]; endproperty
   a_flt: assert property (p_flt) else $error("fault flag without enable");
endmodule // ptb_checker
bind ptb_top ptb_checker ptb_checker_i (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: test/testbench.sv */
// Self-checking bench for the PWM time base block
`timescale 1ns/1ps
module testbench;
   logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h3;
   logic pready, pslverr, special_event, irq, fault_event = 0, current_limit_event = 0, trigger_event = 0;
   int error_cnt = 0, samples_checked = 0, cycles = 0, n;
   ptb_top ptb_top_i (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_event(fault_event), .current_limit_event(current_limit_event), .trigger_event(trigger_event),
      .special_event(special_event), .irq(irq));
   initial
   begin
      forever #50 clock = ~clock;
   end
   task print_verdict();
      if (error_cnt == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Read data and error are taken at the edge that sees pready
   task apb(input logic we, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse(input logic [2:0] ev);
      @(posedge clock);
      {fault_event, current_limit_event, trigger_event} <= ev;
      @(posedge clock);
      {fault_event, current_limit_event, trigger_event} <= 3'b000;
   endtask
   task t_reset();
      apb(0, 12'h000, 0);
      chk(rd, 32'h0000fff8);
      apb(0, 12'h004, 0);
      chk(rd, 32'h0);
      apb(0, 12'h008, 0);
      chk(rd, 32'h0);
   endtask
   // Pulses of the special event are one period plus one apart
   task t_period();
      apb(1, 12'h000, 32'h9);
      apb(1, 12'h004, 32'h4);
      apb(0, 12'h004, 0);
      chk(rd, 32'h4);
      n = 0;
      while (special_event !== 1'b1 && n < 40)
      begin
         @(posedge clock);
         n++;
      end
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (special_event !== 1'b1 && n < 40);
      chk(n, 32'd10);
      apb(0, 12'h010, 0);
      chk(rd & 32'h18, 32'h18);
      apb(0, 12'h00c, 0);
      chk(rd > 32'h9, 32'h0);
   endtask
   task t_gctl();
      apb(1, 12'h008, 32'h1c00);
      pulse(3'b111);
      apb(0, 12'h008, 0);
      chk(rd, 32'hfc00);
      apb(1, 12'h008, 32'h0800);
      apb(0, 12'h008, 0);
      chk(rd, 32'h4800);
      apb(1, 12'h008, 0);
      pulse(3'b111);
      apb(0, 12'h008, 0);
      chk(rd, 32'h0);
      apb(1, 12'h008, 32'hffff);
      apb(0, 12'h008, 0);
      chk(rd, 32'h1fef);
      apb(1, 12'h008, 0);
   endtask
   task t_irq();
      apb(1, 12'h018, 32'h1);
      apb(1, 12'h014, 32'h1f);
      @(posedge clock);
      chk(irq, 0);
      pulse(3'b100);
      @(posedge clock);
      chk(irq, 1);
      apb(0, 12'h010, 0);
      chk(rd & 32'h1, 32'h1);
      apb(1, 12'h018, 0);
      @(posedge clock);
      chk(irq, 0);
      apb(1, 12'h018, 32'h1);
      @(posedge clock);
      chk(irq, 1);
      apb(1, 12'h014, 32'h1);
      @(posedge clock);
      chk(irq, 0);
      apb(0, 12'h01c, 0);
      chk({err, rd[30:0]}, 32'h80000000);
   endtask
   initial
   begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_period();
      t_gctl();
      t_irq();
      print_verdict();
   end
endmodule // testbench
